// ### src/fcc_pkg.sv
// Constants, enumerations and carrier types of the flash command checker
package fcc_pkg;
  // ==========================================================
  // Register offsets on the plain register port
  localparam int FCC_RA_W = 4;
  localparam logic [3:0] FCC_REG_CLKDIV = 4'h0;
  localparam logic [3:0] FCC_REG_CONFIG = 4'h1;
  localparam logic [3:0] FCC_REG_SEC = 4'h2;
  localparam logic [3:0] FCC_REG_PROT = 4'h3;
  localparam logic [3:0] FCC_REG_STAT = 4'h4;
  localparam logic [3:0] FCC_REG_CMD = 4'h5;
  localparam logic [3:0] FCC_REG_MARGIN = 4'h6;
  // ==========================================================
  // Field positions and reset values
  localparam int FCC_ST_CMD_BUFFER_EMPTY_FLAG = 7;
  localparam int FCC_ST_CMD_COMPLETE_FLAG = 6;
  localparam int FCC_ST_PROTECTION_VIOLATION_FLAG = 5;
  localparam int FCC_ST_ACCESS_ERROR_FLAG = 4;
  localparam int FCC_CF_CBIE = 7;
  localparam int FCC_CF_CCIE = 6;
  localparam int FCC_CF_KEY_ACCESS_BIT = 5;
  localparam int FCC_PR_EN = 3;
  localparam int FCC_KIDX_LO = 1;
  localparam int FCC_KRGN_LO = 3;
  localparam logic [7:0] FCC_CFG_RST = 8'h00;
  localparam logic [7:0] FCC_PROT_RST = 8'h00;
  localparam logic [1:0] FCC_SEC_UNSEC = 2'h2;
  localparam logic [1:0] FCC_KEYEN_ON = 2'h2;
  localparam logic [15:0] FCC_KEY_BASE = 16'hFF00;
  localparam int FCC_CNT_W = 8;
  // ==========================================================
  // Command codes and data values
  localparam logic [7:0] FCC_CMD_EV = 8'h05;
  localparam logic [7:0] FCC_CMD_PROG = 8'h20;
  localparam logic [7:0] FCC_CMD_BURST = 8'h25;
  localparam logic [7:0] FCC_CMD_SERASE = 8'h40;
  localparam logic [7:0] FCC_CMD_MERASE = 8'h41;
  localparam logic [7:0] FCC_CMD_MARGIN = 8'h75;
  localparam logic [15:0] FCC_MRG_NORMAL = 16'h0000;
  localparam logic [15:0] FCC_MRG_ZERO = 16'h0005;
  localparam logic [15:0] FCC_MRG_ONE = 16'h0024;
  localparam logic [15:0] FCC_KEY_ZEROS = 16'h0000;
  localparam logic [15:0] FCC_KEY_ONES = 16'hFFFF;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_ADDR = 2'b01,
    SQ_CMD = 2'b11} fcc_seq_t;
  typedef enum logic [1:0] {KS_IDLE = 2'b00, KS_RUN = 2'b01,
    KS_OPEN = 2'b11, KS_LOCK = 2'b10} fcc_key_t;
  typedef enum logic [1:0] {MG_NORMAL = 2'b00, MG_ZERO = 2'b01,
    MG_ONE = 2'b11} fcc_margin_t;
  typedef struct packed {
    logic valid;
    logic byte_acc;
    logic [15:0] addr;
    logic [15:0] data;
  } fcc_flash_wr_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } fcc_op_t;
  typedef struct packed {
    fcc_seq_t seq;
    fcc_op_t seqop;
    fcc_op_t eng;
    fcc_op_t pend;
    logic clkdiv_set;
    logic [7:0] clkdiv;
    logic [7:0] cfg;
    logic [7:0] prot;
    logic cmd_buffer_empty_flag;
    logic cmd_complete_flag;
    logic protection_violation_flag;
    logic access_error_flag;
    logic active;
    logic pending;
    logic [FCC_CNT_W-1:0] busy;
    fcc_margin_t margin;
    fcc_key_t ks;
    logic [1:0] kcnt;
    logic kwr_prev;
    logic stop_prev;
    logic [7:0] rdata;
  } fcc_state_t;
endpackage : fcc_pkg

// ### src/fcc_top.sv
// Flash command checker, mode handling and backdoor key unlock
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RQ1] Margin command 0x75 legal only in special
// [RQ2] Margin data word picks sense level
// [RQ3] Launch by writing one; complete sets
// [RQ4] Flash write before divider set: error
// [RQ5] Byte or misaligned flash write: error
// [RQ6] After address, only command register allowed
// [RQ7] Bad command: error, or violation if protected
// [RQ8] Buffer empty, busy: only burst allowed
// [RQ9] Secured: only verify/mass erase from unsafe
// [RQ10] After command, only status launch allowed
// [RQ11] Writing zero to empty flag aborts
// [RQ12] Stop aborts, purges, drops voltage, flags
// [RQ13] Stop exit sets empty, drops buffered
// [RQ14] Reads never flag; busy reads invalid; the code keeps busy reads valid while the key access bit is set
// [RQ15] Software clears error flags before new sequence
// [RQ16] Protected program/erase/invalid raises violation
// [RQ17] Wait mode runs commands; flags wake
// [RQ18] Debug writes protection; secured limits commands
// [RQ19] Four matching key writes unsecure
// [RQ20] All-zero or all-one keys are illegal
// [RQ21] Bad key sequence locks until reset
// [RQ22] Unlock leaves stored bytes untouched
// [RQ23] Decode the five other command codes
// [RQ24] Error flags clear on write one
// [RQ25] Key path ignored in special debug
module fcc_top #(
  parameter int unsigned OP_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [fcc_pkg::FCC_RA_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire fcc_pkg::fcc_flash_wr_t flash_wr,
  output logic arr_rd_valid,
  input wire logic special_mode,
  input wire logic background_debug_mode,
  input wire logic fetch_secure,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic [7:0] security_byte,
  input wire logic [63:0] stored_keys,
  output logic hv_on,
  output fcc_pkg::fcc_op_t eng_op,
  output logic eng_busy,
  output fcc_pkg::fcc_margin_t margin_level,
  output logic secured,
  output logic wake
);
  import fcc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic prot_hit(input logic [7:0] p,
                                    input logic [15:0] a);
    prot_hit = p[FCC_PR_EN] && (a[15:13] >= p[2:0]);
  endfunction : prot_hit

  function automatic logic [15:0] key_word(input logic [63:0] k,
                                           input logic [1:0] i);
    key_word = k[{i, 4'h0} +: 16];
  endfunction : key_word

  fcc_state_t st_q;
  fcc_state_t st_d;
  logic key_mode;
  logic key_wr;
  logic launch;
  logic [7:0] c;
  logic c_valid;
  logic hit;
  logic seq_bad;
  logic [1:0] kidx;
  logic is_secured;

  assign is_secured = (security_byte[1:0] != FCC_SEC_UNSEC)
    && (st_q.ks != KS_OPEN);
  // Unlock never touches the stored byte, keys or protection [RQ22]
  assign key_mode = (security_byte[7:6] == FCC_KEYEN_ON)
    && st_q.cfg[FCC_CF_KEY_ACCESS_BIT]
    && !(special_mode && background_debug_mode); // [RQ25]
  assign key_wr = flash_wr.valid && key_mode
    && (flash_wr.addr[15:FCC_KRGN_LO] == FCC_KEY_BASE[15:FCC_KRGN_LO]);
  assign kidx = flash_wr.addr[FCC_KIDX_LO +: 2];
  assign c = reg_wdata;
  assign hit = prot_hit(st_q.prot, st_q.seqop.addr);
  // [RQ23] [RQ1]
  assign c_valid = (c == FCC_CMD_EV) || (c == FCC_CMD_PROG)
    || (c == FCC_CMD_BURST) || (c == FCC_CMD_SERASE)
    || (c == FCC_CMD_MERASE)
    || ((c == FCC_CMD_MARGIN) && special_mode);
  assign seq_bad = ((st_q.seq == SQ_ADDR) && (reg_addr != FCC_REG_CMD))
    || ((st_q.seq == SQ_CMD) && (reg_addr != FCC_REG_STAT)); // [RQ6] [RQ10]
  assign launch = reg_wr && !seq_bad && (reg_addr == FCC_REG_STAT)
    && (st_q.seq == SQ_CMD) && reg_wdata[FCC_ST_CMD_BUFFER_EMPTY_FLAG]; // [RQ3]

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    st_d.kwr_prev = key_wr;
    st_d.stop_prev = stop_mode;
    // Register reads have no side effects [RQ14]
    if (reg_rd)
    begin
      case (reg_addr)
        FCC_REG_CLKDIV: st_d.rdata = st_q.clkdiv;
        FCC_REG_CONFIG: st_d.rdata = st_q.cfg;
        FCC_REG_SEC: st_d.rdata = {security_byte[7:2],
          (st_q.ks == KS_OPEN) ? FCC_SEC_UNSEC : security_byte[1:0]};
        FCC_REG_PROT: st_d.rdata = st_q.prot;
        FCC_REG_STAT: st_d.rdata = {st_q.cmd_buffer_empty_flag, st_q.cmd_complete_flag, st_q.protection_violation_flag,
          st_q.access_error_flag, 4'h0};
        FCC_REG_CMD: st_d.rdata = st_q.seqop.cmd;
        FCC_REG_MARGIN: st_d.rdata = {6'h00, st_q.margin};
        default: st_d.rdata = 8'h00;
      endcase
    end
    // Engine runs on in wait mode; only stop cuts it short [RQ17]
    if (st_q.active)
    begin
      if (st_q.busy != '0)
        st_d.busy = st_q.busy - 1'b1;
      else if (st_q.pending)
      begin
        st_d.eng = st_q.pend;
        st_d.pending = 1'b0;
        st_d.cmd_buffer_empty_flag = 1'b1;
        st_d.busy = FCC_CNT_W'(OP_CYCLES - 1);
      end
      else
      begin
        st_d.active = 1'b0;
        st_d.cmd_complete_flag = 1'b1; // [RQ3]
      end
    end
    // Register writes
    if (reg_wr)
    begin
      if (seq_bad)
      begin
        st_d.access_error_flag = 1'b1; // [RQ6] [RQ10]
        st_d.seq = SQ_IDLE;
      end
      else
      begin
        case (reg_addr)
          FCC_REG_CLKDIV:
          begin
            st_d.clkdiv = reg_wdata;
            st_d.clkdiv_set = 1'b1;
          end
          FCC_REG_CONFIG: st_d.cfg = reg_wdata;
          FCC_REG_PROT:
          begin
            // Only the debugger may rewrite protection [RQ18]
            if (background_debug_mode)
              st_d.prot = reg_wdata;
          end
          FCC_REG_STAT:
          begin
            // Write one clears; hardware sets below win [RQ24]
            if (reg_wdata[FCC_ST_ACCESS_ERROR_FLAG])
              st_d.access_error_flag = 1'b0;
            if (reg_wdata[FCC_ST_PROTECTION_VIOLATION_FLAG])
              st_d.protection_violation_flag = 1'b0;
            if (st_q.seq == SQ_CMD)
            begin
              st_d.seq = SQ_IDLE;
              if (!reg_wdata[FCC_ST_CMD_BUFFER_EMPTY_FLAG])
                st_d.access_error_flag = 1'b1; // [RQ11]
              else if (!st_d.active)
              begin
                st_d.active = 1'b1;
                st_d.cmd_complete_flag = 1'b0;
                st_d.eng = st_q.seqop;
                st_d.busy = FCC_CNT_W'(OP_CYCLES - 1);
              end
              else
              begin
                // Second burst waits in the one-deep buffer
                st_d.pending = 1'b1;
                st_d.pend = st_q.seqop;
                st_d.cmd_buffer_empty_flag = 1'b0;
              end
              if (st_q.seqop.cmd == FCC_CMD_MARGIN)
              begin
                // Other data words leave the level as it was [RQ2]
                case (st_q.seqop.data)
                  FCC_MRG_NORMAL: st_d.margin = MG_NORMAL;
                  FCC_MRG_ZERO: st_d.margin = MG_ZERO;
                  FCC_MRG_ONE: st_d.margin = MG_ONE;
                  default: st_d.margin = st_q.margin;
                endcase
              end
            end
          end
          FCC_REG_CMD:
          begin
            if (st_q.seq == SQ_ADDR)
            begin
              st_d.seq = SQ_IDLE;
              if (!c_valid)
              begin
                if (hit)
                  st_d.protection_violation_flag = 1'b1; // [RQ16] [RQ7]
                else
                  st_d.access_error_flag = 1'b1; // [RQ7]
              end
              else if (st_q.cmd_buffer_empty_flag && !st_q.cmd_complete_flag && c != FCC_CMD_BURST)
                st_d.access_error_flag = 1'b1; // [RQ8]
              else if (is_secured
                && (!fetch_secure || background_debug_mode)
                && c != FCC_CMD_EV && c != FCC_CMD_MERASE)
                st_d.access_error_flag = 1'b1; // [RQ9] [RQ18]
              else if (((c == FCC_CMD_PROG || c == FCC_CMD_BURST
                || c == FCC_CMD_SERASE) && hit)
                || (c == FCC_CMD_MERASE && st_q.prot[FCC_PR_EN]))
                st_d.protection_violation_flag = 1'b1; // [RQ16]
              else
              begin
                st_d.seq = SQ_CMD;
                st_d.seqop.cmd = c;
              end
            end
          end
          default: st_d.seq = st_q.seq;
        endcase
      end
    end
    // Flash array writes
    if (key_wr)
    begin
      // Key compare; any flaw locks for good [RQ19] [RQ20] [RQ21]
      if (st_q.ks == KS_IDLE || st_q.ks == KS_RUN)
      begin
        if (kidx == st_q.kcnt && !st_q.kwr_prev
          && flash_wr.data == key_word(stored_keys, kidx)
          && flash_wr.data != FCC_KEY_ZEROS
          && flash_wr.data != FCC_KEY_ONES && !flash_wr.byte_acc)
        begin
          st_d.kcnt = st_q.kcnt + 1'b1;
          st_d.ks = (st_q.kcnt == 2'h3) ? KS_OPEN : KS_RUN;
        end
        else
          st_d.ks = KS_LOCK;
      end
    end
    else if (flash_wr.valid)
    begin
      if (st_q.access_error_flag || st_q.protection_violation_flag)
        st_d.seq = st_q.seq; // Sequence blocked until flags cleared [RQ15]
      else if (!st_q.clkdiv_set)
        st_d.access_error_flag = 1'b1; // [RQ4]
      else if (st_q.seq != SQ_IDLE || !st_q.cmd_buffer_empty_flag)
      begin
        st_d.access_error_flag = 1'b1; // [RQ6] [RQ10]
        st_d.seq = SQ_IDLE;
      end
      else if (flash_wr.byte_acc || flash_wr.addr[0])
        st_d.access_error_flag = 1'b1; // [RQ5]
      else
      begin
        st_d.seq = SQ_ADDR;
        st_d.seqop.addr = flash_wr.addr;
        st_d.seqop.data = flash_wr.data;
      end
    end
    // Key access dropped early, or stop mid-sequence, locks [RQ21]
    if (st_q.ks == KS_RUN && (!st_q.cfg[FCC_CF_KEY_ACCESS_BIT] || stop_mode))
      st_d.ks = KS_LOCK;
    // Stop entry kills the running command and its buffer [RQ12]
    if (stop_mode && !st_q.stop_prev && st_q.active)
    begin
      st_d.active = 1'b0;
      st_d.pending = 1'b0;
      st_d.access_error_flag = 1'b1;
      st_d.cmd_complete_flag = 1'b1;
    end
    // Stop exit empties the buffer without launching it [RQ13]
    if (!stop_mode && st_q.stop_prev)
    begin
      st_d.cmd_buffer_empty_flag = 1'b1;
      st_d.pending = 1'b0;
      st_d.seq = SQ_IDLE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.cfg <= FCC_CFG_RST;
      st_q.prot <= FCC_PROT_RST;
      st_q.cmd_buffer_empty_flag <= 1'b1;
      st_q.cmd_complete_flag <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = st_q.rdata;
  // Busy array reads are invalid, key access keeps them valid [RQ14] [RQ19]
  assign arr_rd_valid = !st_q.active || st_q.cfg[FCC_CF_KEY_ACCESS_BIT];
  // Gated at once by stop, not one cycle later [RQ12]
  assign hv_on = st_q.active && !stop_mode;
  assign eng_op = st_q.eng;
  assign eng_busy = st_q.active;
  assign margin_level = st_q.margin;
  assign secured = is_secured;
  // [RQ17]
  assign wake = wait_mode
    && ((st_q.cmd_buffer_empty_flag && st_q.cfg[FCC_CF_CBIE])
    || (st_q.cmd_complete_flag && st_q.cfg[FCC_CF_CCIE]));

  // ==========================================================
  // Assertions
  a_stop_abort: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
    stop_mode && !st_q.stop_prev && st_q.active
    |=> st_q.access_error_flag && st_q.cmd_complete_flag && !st_q.active && !st_q.pending)
    else $error("stop did not abort the command");
  a_stop_exit: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
    !stop_mode && st_q.stop_prev |=> st_q.cmd_buffer_empty_flag && !st_q.pending)
    else $error("stop exit left buffer full");
  a_clkdiv_first: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
    flash_wr.valid && !key_wr && !st_q.clkdiv_set && !st_q.access_error_flag
    && !st_q.protection_violation_flag |=> st_q.access_error_flag && st_q.seq == SQ_IDLE)
    else $error("early flash write not flagged");
  a_byte_write: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
    flash_wr.valid && !key_wr && flash_wr.byte_acc && st_q.clkdiv_set
    && !st_q.access_error_flag && !st_q.protection_violation_flag |=> st_q.access_error_flag)
    else $error("byte flash write not flagged");
  a_zero_launch: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
    reg_wr && reg_addr == FCC_REG_STAT && st_q.seq == SQ_CMD
    && !reg_wdata[FCC_ST_CMD_BUFFER_EMPTY_FLAG] |=> st_q.access_error_flag && st_q.seq == SQ_IDLE)
    else $error("zero write did not abort");
  a_lock_holds: assert property (@(posedge mclk) disable iff (rst) // [RQ21]
    st_q.ks == KS_LOCK |=> st_q.ks == KS_LOCK && $stable(st_q.kcnt))
    else $error("key lock released");
  a_bad_key: assert property (@(posedge mclk) disable iff (rst) // [RQ20]
    key_wr && st_q.ks != KS_OPEN && (flash_wr.data == FCC_KEY_ZEROS
    || flash_wr.data == FCC_KEY_ONES) |=> st_q.ks == KS_LOCK)
    else $error("illegal key accepted");
  a_op_done: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
    launch && !st_q.active && !stop_mode
    |=> !st_q.cmd_complete_flag ##(OP_CYCLES) st_q.cmd_complete_flag || st_q.active)
    else $error("command complete timing wrong");
  a_margin_zero: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
    launch && st_q.seqop.cmd == FCC_CMD_MARGIN
    && st_q.seqop.data == FCC_MRG_ZERO |=> margin_level == MG_ZERO)
    else $error("margin level not applied");

endmodule : fcc_top

`default_nettype wire

// ### verif/test_fcc_top.sv
// Self-checking testbench of the flash command checker
`timescale 1ns/1ps
`default_nettype none
module test_fcc_top;
  import fcc_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  typedef struct packed {logic [3:0] a; logic [7:0] v;} fcc_exp_t;
  logic mclk, rst, reg_wr, reg_rd, arr_rd_valid, special_mode;
  logic background_debug_mode, fetch_secure, stop_mode, wait_mode;
  logic hv_on, eng_busy, secured, wake;
  logic rd_seen = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, security_byte;
  logic [63:0] stored_keys;
  logic [15:0] kw [4];
  fcc_flash_wr_t fwr;
  fcc_op_t eng_op;
  fcc_margin_t margin_level;
  fcc_exp_t expq [$];
  fcc_exp_t e;
  int failures, checked;
  // Short algorithm so that back-to-back cases fit inside one op
  fcc_top #(.OP_CYCLES(8)) DUT (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_wr(fwr),
    .arr_rd_valid(arr_rd_valid), .special_mode(special_mode),
    .background_debug_mode(background_debug_mode),
    .fetch_secure(fetch_secure), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .security_byte(security_byte),
    .stored_keys(stored_keys), .hv_on(hv_on), .eng_op(eng_op),
    .eng_busy(eng_busy), .margin_level(margin_level),
    .secured(secured), .wake(wake));
  // ==========================================================
  // Clock, checks and closing
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task chk(input string n, input logic [15:0] got, input logic [15:0] ex);
    checked++;
    if (got !== ex)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, ex, got);
    end
  endtask : chk
  task stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Read data stands for one cycle only, so it is taken at that edge
  always @(posedge mclk)
  begin
    if (rd_seen)
    begin
      e = expq.pop_front();
      chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e.v});
    end
    rd_seen <= reg_rd;
  end
  initial
  begin
    #400000;
    failures++;
    stop_test();
  end
  // ==========================================================
  // Bus tasks
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] ex);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back('{a: a, v: ex});
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd
  task fw(input logic [15:0] a, input logic [15:0] d, input logic b);
    @(posedge mclk);
    fwr <= '{valid: 1'b1, byte_acc: b, addr: a, data: d};
    @(posedge mclk);
    fwr.valid <= 1'b0;
  endtask : fw
  task seq(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    fw(a, d, 1'b0);
    wr(FCC_REG_CMD, c);
    wr(FCC_REG_STAT, 8'h80);
  endtask : seq
  // Status read, then both error flags cleared by writing ones
  task err(input logic [7:0] ex);
    rd(FCC_REG_STAT, ex);
    wr(FCC_REG_STAT, 8'h30);
  endtask : err
  task done;
    int n;
    n = 0;
    repeat (2) @(posedge mclk);
    while (eng_busy !== 1'b0 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    chk("eng_busy", {15'h0, eng_busy}, 16'h0000);
  endtask : done
  task do_rst;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_rst
  task keys(input logic [15:0] k0);
    fw(FCC_KEY_BASE, k0, 1'b0);
    for (int i = 1; i < 4; i++)
      fw(FCC_KEY_BASE + 16'(2 * i), kw[i], 1'b0);
    @(posedge mclk);
  endtask : keys
  // ==========================================================
  // Scenarios
  logic [7:0] cmds [4] = '{FCC_CMD_EV, FCC_CMD_PROG, FCC_CMD_SERASE,
    FCC_CMD_MERASE};
  logic [15:0] lvls [3] = '{FCC_MRG_NORMAL, FCC_MRG_ZERO, FCC_MRG_ONE};
  fcc_margin_t mexp [3] = '{MG_NORMAL, MG_ZERO, MG_ONE};
  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, special_mode, background_debug_mode} = '0;
    {stop_mode, wait_mode, fetch_secure, reg_addr, reg_wdata} = '0;
    fwr = '0;
    security_byte = 8'h02;
    failures = 0;
    checked = 0;
    void'($urandom(64));
    for (int i = 0; i < 4; i++)
      kw[i] = {16'($urandom()) & 16'hFFFC} | 16'h0002;
    stored_keys = {kw[3], kw[2], kw[1], kw[0]};
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(FCC_REG_STAT, 8'hC0);
    rd(FCC_REG_PROT, 8'h00);
    fw(16'h2000, 16'($urandom()), 1'b0);
    rd(FCC_REG_STAT, 8'hD0);
    wr(FCC_REG_STAT, 8'h00);
    rd(FCC_REG_STAT, 8'hD0);
    err(8'hD0);
    rd(FCC_REG_STAT, 8'hC0);
    wr(FCC_REG_CLKDIV, 8'($urandom()) | 8'h01);
    foreach (cmds[i])
    begin
      seq(16'h2000, 16'($urandom()), cmds[i]);
      // Launch edge updates the engine; look once it has settled
      @(negedge mclk);
      chk("eng_op.cmd", {8'h00, eng_op.cmd}, {8'h00, cmds[i]});
      chk("hv_on", {15'h0, hv_on}, 16'h0001);
      chk("arr_rd_valid", {15'h0, arr_rd_valid}, 16'h0000);
      done();
      chk("arr_rd_valid", {15'h0, arr_rd_valid}, 16'h0001);
      rd(FCC_REG_STAT, 8'hC0);
    end
    fw(16'h2000, 16'h1234, 1'b1);
    err(8'hD0);
    fw(16'h2001, 16'h1234, 1'b0);
    err(8'hD0);
    fw(16'h2000, 16'h1234, 1'b0);
    fw(16'h2002, 16'h1234, 1'b0);
    err(8'hD0);
    fw(16'h2000, 16'h1234, 1'b0);
    wr(FCC_REG_CONFIG, 8'h40);
    err(8'hD0);
    fw(16'h2000, 16'h1234, 1'b0);
    wr(FCC_REG_CMD, FCC_CMD_PROG);
    wr(FCC_REG_CONFIG, 8'h40);
    err(8'hD0);
    rd(FCC_REG_CONFIG, 8'h00);
    fw(16'h2000, 16'h1234, 1'b0);
    wr(FCC_REG_CMD, FCC_CMD_PROG);
    wr(FCC_REG_STAT, 8'h00);
    err(8'hD0);
    seq(16'h2000, 16'h0000, 8'h33);
    err(8'hD0);
    seq(16'h2000, 16'h0000, FCC_CMD_MARGIN);
    err(8'hD0);
    special_mode <= 1'b1;
    foreach (lvls[i])
    begin
      seq(16'h2000, lvls[i], FCC_CMD_MARGIN);
      done();
      chk("margin_level", {14'h0, margin_level}, {14'h0, mexp[i]});
    end
    special_mode <= 1'b0;
    background_debug_mode <= 1'b1;
    wr(FCC_REG_PROT, 8'h0C);
    background_debug_mode <= 1'b0;
    wr(FCC_REG_PROT, 8'h00);
    rd(FCC_REG_PROT, 8'h0C);
    seq(16'h8000, 16'h0000, 8'h33);
    err(8'hE0);
    seq(16'h8000, 16'h5555, FCC_CMD_PROG);
    err(8'hE0);
    seq(16'h8000, 16'h0000, FCC_CMD_SERASE);
    err(8'hE0);
    seq(16'h2000, 16'h0000, FCC_CMD_MERASE);
    err(8'hE0);
    seq(16'h2000, 16'h0001, FCC_CMD_BURST);
    fw(16'h2002, 16'h0002, 1'b0);
    wr(FCC_REG_CMD, FCC_CMD_PROG);
    done();
    err(8'hD0);
    // Second burst is buffered while the first runs, then takes over
    seq(16'h2000, 16'h0006, FCC_CMD_BURST);
    seq(16'h2002, 16'h0007, FCC_CMD_BURST);
    rd(FCC_REG_STAT, 8'h00);
    done();
    chk("eng_op.addr", eng_op.addr, 16'h2002);
    rd(FCC_REG_STAT, 8'hC0);
    wait_mode <= 1'b1;
    wr(FCC_REG_CONFIG, 8'h80);
    @(posedge mclk);
    chk("wake", {15'h0, wake}, 16'h0001);
    seq(16'h2000, 16'h0003, FCC_CMD_PROG);
    done();
    rd(FCC_REG_STAT, 8'hC0);
    wait_mode <= 1'b0;
    seq(16'h2000, 16'h0004, FCC_CMD_PROG);
    stop_mode <= 1'b1;
    #1;
    chk("hv_on", {15'h0, hv_on}, 16'h0000);
    repeat (2) @(posedge mclk);
    chk("eng_busy", {15'h0, eng_busy}, 16'h0000);
    stop_mode <= 1'b0;
    err(8'hD0);
    // Key unlock, then two fresh resets, each with a wrong first key
    do_rst();
    security_byte <= 8'h80;
    wr(FCC_REG_CONFIG, 8'h20);
    keys(kw[0]);
    chk("secured", {15'h0, secured}, 16'h0000);
    rd(FCC_REG_SEC, 8'h82);
    do_rst();
    chk("secured", {15'h0, secured}, 16'h0001);
    wr(FCC_REG_CONFIG, 8'h20);
    keys(FCC_KEY_ONES);
    keys(kw[0]);
    chk("secured", {15'h0, secured}, 16'h0001);
    do_rst();
    wr(FCC_REG_CONFIG, 8'h20);
    keys(kw[0] ^ 16'h0004);
    keys(kw[0]);
    chk("secured", {15'h0, secured}, 16'h0001);
    wr(FCC_REG_CONFIG, 8'h00);
    wr(FCC_REG_CLKDIV, 8'h01);
    seq(16'h2000, 16'h0005, FCC_CMD_PROG);
    err(8'hD0);
    seq(16'h2000, 16'h0000, FCC_CMD_EV);
    done();
    rd(FCC_REG_STAT, 8'hC0);
    repeat (3) @(posedge mclk);
    stop_test();
  end
endmodule : test_fcc_top
`default_nettype wire
